// ===== verif/core_model.sv
// Behavioural model of the processor core as seen from the request lines.
// Assumes one clock shared with the block; it answers only while told to.
`timescale 1ns/100ps
module core_model (
    input wire logic clock, // System clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic high_irq_req, // High or compatible request
    input wire logic low_irq_req, // Low priority request
    input wire logic [23:0] irq_vector, // Vector offered with the request
    input wire logic ack_on, // Bench lets the core answer
    input wire integer ack_wait, // Cycles the core waits before answering
    output logic irq_ack, // One-cycle answer pulse
    output logic [23:0] taken_vector, // Vector fetched at the answer
    output int ack_count // Answers given so far
);
    int waited;
    int hold;

    // Answer after a chosen delay, then stay quiet while the request drops,
    // because the block needs two cycles to withdraw a served request
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_ack <= 1'b0;
            taken_vector <= 24'h00_0000;
            ack_count <= 0;
            waited <= 0;
            hold <= 0;
        end else begin
            irq_ack <= 1'b0;
            if (irq_ack) begin
                hold <= 3;
            end else if (hold > 0) begin
                hold <= hold - 1;
            end else if (ack_on && (high_irq_req || low_irq_req)) begin
                if (waited >= ack_wait) begin
                    irq_ack <= 1'b1;
                    taken_vector <= irq_vector; // Core jumps to the offered vector
                    ack_count <= ack_count + 1;
                    waited <= 0;
                end else begin
                    waited <= waited + 1;
                end
            end
        end
    end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the interrupt control flag block.
// Assumes the core model answers requests; the bench plays software and sources.
`timescale 1ns/100ps
module tb;
    import irq_ctl_pkg::*;
    logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, timer_zero_overflow = 1'b0;
    logic port_b_read = 1'b0, parallel_port_access = 1'b0, converter_done = 1'b0, sync_serial_done = 1'b0;
    logic serial_receive_full = 1'b0, serial_transmit_empty = 1'b0, ack_on = 1'b0;
    logic irq_ack, high_irq_req, low_irq_req;
    logic [2:0] reg_addr = 3'h0, ext_line_in = 3'h0;
    logic [3:0] upper_port_nibble = 4'h0;
    logic [7:0] reg_wdata = 8'h00, periph_enable = 8'h00, reg_rdata, pullup_en;
    logic [23:0] irq_vector, taken_vector;
    int mismatches = 0, samples_checked = 0, ack_count;

    irq_ctl_flags u_dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_zero_overflow(timer_zero_overflow),
        .ext_line_in(ext_line_in), .upper_port_nibble(upper_port_nibble), .port_b_read(port_b_read),
        .port_latch(8'hA5), .parallel_port_access(parallel_port_access), .converter_done(converter_done),
        .sync_serial_done(sync_serial_done), .periph_low_event(3'h0), .serial_receive_full(serial_receive_full),
        .serial_transmit_empty(serial_transmit_empty), .periph_enable(periph_enable),
        .periph_priority(8'h00), .irq_ack(irq_ack), .high_irq_req(high_irq_req), .low_irq_req(low_irq_req),
        .irq_vector(irq_vector), .pullup_en(pullup_en));

    core_model u_core (.clock(clock), .rst_b(rst_b), .high_irq_req(high_irq_req), .low_irq_req(low_irq_req),
        .irq_vector(irq_vector), .ack_on(ack_on), .ack_wait(2), .irq_ack(irq_ack),
        .taken_vector(taken_vector), .ack_count(ack_count));

    // Clock at 100 MHz
    initial forever #5 clock = ~clock;

    task automatic chk(string name, logic [23:0] exp, logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    // Bus cycles change signals just after an edge and hold one cycle
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdchk(string name, logic [2:0] a, logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(name, 24'(e), 24'(reg_rdata));
    endtask

    task automatic idle(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic pulse_timer();
        @(posedge clock) timer_zero_overflow <= 1'b1;
        @(posedge clock) timer_zero_overflow <= 1'b0;
    endtask

    // Let the core answer once; bounded so a missing request cannot hang
    task automatic wait_ack();
        int n0;
        n0 = ack_count;
        ack_on <= 1'b1;
        for (int k = 0; k < 20 && ack_count == n0; k++) @(posedge clock);
        ack_on <= 1'b0;
        idle(3);
        chk("core answer", 24'(n0 + 1), 24'(ack_count));
    endtask

    task automatic t_reset();
        logic [7:0] exp [6] = '{8'h00, 8'hF5, 8'hC0, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) rdchk("reset value", 3'(i), exp[i]);
        chk("pullups after reset", 24'h00_0000, 24'(pullup_en));
        $display("test reset done");
    endtask

    task automatic t_unimpl();
        wr(EDGE_PRIO_IDX, 8'hFF);
        rdchk("edge reg holes", EDGE_PRIO_IDX, 8'hF5);
        wr(EXT_LINE_IDX, 8'hFF);
        rdchk("line reg holes", EXT_LINE_IDX, 8'hDB);
        wr(3'h6, 8'hFF);
        rdchk("unmapped", 3'h6, 8'h00);
        wr(EXT_LINE_IDX, 8'hC0);
        rdchk("line flags cleared", EXT_LINE_IDX, 8'hC0);
        $display("test unimplemented done");
    endtask

    task automatic t_pullup();
        wr(EDGE_PRIO_IDX, 8'h75);
        idle(2);
        chk("pullups follow latch", 24'h00_00A5, 24'(pullup_en));
        wr(EDGE_PRIO_IDX, 8'hF5);
        idle(2);
        chk("pullups disabled", 24'h00_0000, 24'(pullup_en));
        $display("test pullup done");
    endtask

    // Flag sets with every enable off; a live mismatch keeps re-setting it
    task automatic t_port();
        @(posedge clock) upper_port_nibble <= 4'h9;
        idle(2);
        rdchk("port change flag", CORE_CTL_IDX, 8'h01);
        chk("no request while masked", 24'h00_0000, 24'(high_irq_req));
        wr(CORE_CTL_IDX, 8'h00);
        rdchk("mismatch re-sets", CORE_CTL_IDX, 8'h01);
        @(posedge clock) port_b_read <= 1'b1;
        @(posedge clock) port_b_read <= 1'b0;
        wr(CORE_CTL_IDX, 8'h00);
        rdchk("cleared after port read", CORE_CTL_IDX, 8'h00);
        $display("test port change done");
    endtask

    task automatic t_periph();
        serial_receive_full <= 1'b1;
        @(posedge clock) {parallel_port_access, converter_done, sync_serial_done} <= 3'h7;
        @(posedge clock) {parallel_port_access, converter_done, sync_serial_done} <= 3'h0;
        idle(1);
        rdchk("peripheral flags", PERIPH_FLAGS_IDX, 8'hE8);
        wr(PERIPH_FLAGS_IDX, 8'h00);
        rdchk("read-only receive", PERIPH_FLAGS_IDX, 8'h20);
        serial_receive_full <= 1'b0;
        serial_transmit_empty <= 1'b1;
        idle(2);
        rdchk("transmit empty", PERIPH_FLAGS_IDX, 8'h10);
        serial_transmit_empty <= 1'b0;
        $display("test peripheral flags done");
    endtask

    // Each line with each edge polarity; a rising edge must not flag while falling is selected
    task automatic t_edges();
        logic [2:0] a;
        logic [7:0] base;
        int b;
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? CORE_CTL_IDX : EXT_LINE_IDX;
            base = (i == 0) ? 8'h00 : 8'hC0;
            b = (i == 0) ? EXT0_FLAG_BIT : ((i == 1) ? EXT1_FLAG_BIT : EXT2_FLAG_BIT);
            for (int p = 0; p < 2; p++) begin
                wr(EDGE_PRIO_IDX, (p == 1) ? 8'hF5 : 8'h85);
                wr(a, base); // Flag cleared before watching
                @(posedge clock) ext_line_in[i] <= 1'b1;
                idle(2);
                rdchk("rising edge flag", a, base | (8'(p) << b));
                @(posedge clock) ext_line_in[i] <= 1'b0;
                idle(2);
                rdchk("falling edge flag", a, base | (8'h01 << b));
            end
        end
        wr(CORE_CTL_IDX, 8'h00);
        wr(EXT_LINE_IDX, 8'hC0);
        $display("test edges done");
    endtask

    task automatic t_compat();
        wr(PERIPH_FLAGS_IDX, 8'h00); // Clear before enabling
        periph_enable <= 8'h40;
        @(posedge clock) converter_done <= 1'b1;
        @(posedge clock) converter_done <= 1'b0;
        wr(CORE_CTL_IDX, 8'h80);
        idle(3);
        chk("peripheral gate off", 24'h00_0000, 24'(high_irq_req));
        wr(CORE_CTL_IDX, 8'hC0);
        idle(3);
        chk("compatible request", 24'h00_0001, 24'(high_irq_req));
        chk("compatible vector", VEC_HIGH, irq_vector);
        chk("no low in compatible", 24'h00_0000, 24'(low_irq_req));
        wr(CORE_CTL_IDX, 8'h40);
        idle(3);
        chk("global gate off", 24'h00_0000, 24'(high_irq_req));
        wr(PERIPH_FLAGS_IDX, 8'h00);
        periph_enable <= 8'h00;
        wr(CORE_CTL_IDX, 8'hA0);
        pulse_timer();
        wait_ack();
        chk("vector taken", VEC_HIGH, taken_vector);
        rdchk("global cleared on answer", CORE_CTL_IDX, 8'h24);
        wr(CORE_CTL_IDX, 8'h00);
        $display("test compatible mode done");
    endtask

    task automatic t_prio();
        wr(RESET_CTL_IDX, 8'h80);
        rdchk("priority mode bit", RESET_CTL_IDX, 8'h80);
        wr(EDGE_PRIO_IDX, 8'hF1);
        wr(CORE_CTL_IDX, 8'hE0);
        pulse_timer();
        idle(3);
        chk("low request", 24'h00_0001, 24'(low_irq_req));
        chk("no high request", 24'h00_0000, 24'(high_irq_req));
        chk("low vector", VEC_LOW, irq_vector);
        wait_ack();
        chk("low vector taken", VEC_LOW, taken_vector);
        rdchk("low gate cleared", CORE_CTL_IDX, 8'hA4);
        wr(EDGE_PRIO_IDX, 8'hF5);
        idle(3);
        chk("high request", 24'h00_0001, 24'(high_irq_req));
        chk("high vector", VEC_HIGH, irq_vector);
        wr(CORE_CTL_IDX, 8'h24);
        idle(3);
        chk("high gate off", 24'h00_0000, 24'(high_irq_req));
        wr(RESET_CTL_IDX, 8'h00);
        wr(CORE_CTL_IDX, 8'h00);
        $display("test priority mode done");
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Tests take a few hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_reset();
        t_unimpl();
        t_pullup();
        t_port();
        t_periph();
        t_edges();
        t_compat();
        t_prio();
        tally_and_finish();
    end
endmodule

// ===== verilog/edge_if.sv
// Interface joining the controller to its external line edge detector.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface edge_if;
    logic [2:0] line_in;
    logic [2:0] edge_sel;
    logic [2:0] edge_hit;

    modport detector (input line_in, input edge_sel, output edge_hit);
    modport control (output line_in, output edge_sel, input edge_hit);
endinterface

// ===== verilog/ext_edge_detect.sv
// Edge detector for the three external interrupt lines.
// Assumes the lines are already synchronous to clock.
`timescale 1ns/100ps
module ext_edge_detect
    import irq_ctl_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic rst_b, // Asynchronous reset, active low
    edge_if.detector lines // Lines, edge selects and hit pulses
);

    logic [2:0] prev_ff;

    // Previous level, reset low so a high line after reset reads as rising
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prev_ff <= 3'h0;
        end else begin
            prev_ff <= lines.line_in;
        end
    end

    // One hit pulse per line on the selected edge
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_line
            assign lines.edge_hit[gi] = lines.edge_sel[gi] ? (lines.line_in[gi] && !prev_ff[gi]) :
                                        (!lines.line_in[gi] && prev_ff[gi]); // [R13]
        end
    endgenerate

endmodule

// ===== verilog/irq_ctl_flags.sv
// Interrupt control and flag registers with request forming for the core.
// Assumes all source inputs are synchronous to clock and event inputs
// are one-cycle pulses; peripheral enable and priority bits come in as ports.
//
// Summary of operation
// R1: Flags set regardless of any enable
// R2: Software clears flags before enabling, after servicing
// R3: Compatible mode: bit 7 gates every interrupt
// R4: Priority mode: bit 7 gates high priority
// R5: Compatible mode: bit 6 gates peripheral interrupts
// R6: Priority mode: bit 6 gates low priority
// R7: Bits 5..3 enable timer, line zero, port
// R8: Timer overflow sets bit 2 until cleared
// R9: Selected line zero edge sets bit 1
// R10: Upper port nibble change sets bit 0
// R11: Mismatch keeps setting; port read ends it
// R12: Pull-up disable bit forces pull-ups off
// R13: Edge selects: one rising, zero falling
// R14: Timer and port change priority bits
// R15: Line two and one priority, reset high
// R16: Line two and one individual enables
// R17: Line two and one flags until cleared
// R18: Unimplemented bits read zero, ignore writes
// R19: Parallel port access sets flag bit 7
// R20: Converter and sync serial done flags
// R21: Receive flag follows buffer full, read-only
// R22: Transmit flag follows buffer empty, read-only
// R23: Priority mode bit selects priority operation
// R24: Vector high or compatible 08h, low 18h
// R25: Response clears the enabling global bit
// R26: Request is flag, enable, global gate
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module irq_ctl_flags
    import irq_ctl_pkg::*;
(
    input wire logic clock, // System clock, 100 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [2:0] reg_addr, // Register index
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after the strobe
    input wire logic timer_zero_overflow, // Timer 0 overflow pulse
    input wire logic [2:0] ext_line_in, // External interrupt lines 0..2
    input wire logic [3:0] upper_port_nibble, // Port B pins 7..4
    input wire logic port_b_read, // Pulse: software read port B
    input wire logic [7:0] port_latch, // Port B output latch values
    input wire logic parallel_port_access, // Parallel port read or write pulse
    input wire logic converter_done, // Conversion complete pulse
    input wire logic sync_serial_done, // Sync serial transfer done pulse
    input wire logic [2:0] periph_low_event, // Pulses for flag bits 2..0
    input wire logic serial_receive_full, // Receive buffer full level
    input wire logic serial_transmit_empty, // Transmit buffer empty level
    input wire logic [7:0] periph_enable, // Peripheral individual enables
    input wire logic [7:0] periph_priority, // Peripheral priorities, 1 high
    input wire logic irq_ack, // Core responds to a request, pulse
    output logic high_irq_req, // High priority request to core
    output logic low_irq_req, // Low priority request to core
    output logic [23:0] irq_vector, // Vector for the pending request
    output logic [7:0] pullup_en // Port B pull-up enables
);

    logic [7:0] core_ctl_ff;
    logic [7:0] edge_prio_ff;
    logic [7:0] ext_line_ff;
    logic [7:0] periph_flags_ff;
    logic prio_mode_ff;
    logic [3:0] port_seen_ff;
    logic [7:0] reg_rdata_ff;
    logic high_irq_req_ff;
    logic low_irq_req_ff;
    logic [23:0] irq_vector_ff;
    logic [7:0] pullup_en_ff;

    edge_if ext_lines();

    // External line edges are found in the detector
    ext_edge_detect u_edges (
        .clock(clock),
        .rst_b(rst_b),
        .lines(ext_lines)
    );

    assign ext_lines.line_in = ext_line_in;
    assign ext_lines.edge_sel = {edge_prio_ff[EDGE2_BIT], edge_prio_ff[EDGE1_BIT], edge_prio_ff[EDGE0_BIT]};

    // Address decode
    wire sel_core = (reg_addr == CORE_CTL_IDX);
    wire sel_edge = (reg_addr == EDGE_PRIO_IDX);
    wire sel_ext = (reg_addr == EXT_LINE_IDX);
    wire sel_periph = (reg_addr == PERIPH_FLAGS_IDX);
    wire sel_rst = (reg_addr == RESET_CTL_IDX);
    wire wr_core = reg_wr && sel_core;
    wire wr_edge = reg_wr && sel_edge;
    wire wr_ext = reg_wr && sel_ext;
    wire wr_periph = reg_wr && sel_periph;
    wire wr_rst = reg_wr && sel_rst;

    // Port change: the pins are compared with the value seen at the last port read
    wire port_mismatch = (upper_port_nibble != port_seen_ff); // [R10] [R11]

    // Hardware set events; these win over a software clear in the same cycle
    wire [7:0] core_set = {5'h00, timer_zero_overflow, ext_lines.edge_hit[0], port_mismatch}; // [R1] [R8] [R9]
    wire [7:0] ext_set = {6'h00, ext_lines.edge_hit[2], ext_lines.edge_hit[1]}; // [R17]
    wire [7:0] periph_set = {parallel_port_access, converter_done, 2'h0, sync_serial_done,
                             periph_low_event}; // [R19] [R20]

    // Core response clears the global bit that admitted the request
    wire clr_high_gate = irq_ack && (!prio_mode_ff || high_irq_req_ff); // [R25]
    wire clr_low_gate = irq_ack && prio_mode_ff && !high_irq_req_ff; // [R25]

    // Core control next value: written bits, then set events, then response clears
    wire [7:0] core_written = wr_core ? reg_wdata : core_ctl_ff;
    wire [7:0] core_flagged = core_written | core_set;
    wire [7:0] nxt_core_ctl = {core_flagged[GLOBAL_EN_BIT] && !clr_high_gate,
                               core_flagged[PERIPH_EN_BIT] && !clr_low_gate,
                               core_flagged[5:0]};

    // Partly populated registers keep unimplemented bits at zero
    wire [7:0] nxt_edge_prio = wr_edge ? (reg_wdata & EDGE_PRIO_MASK) : edge_prio_ff; // [R18]
    wire [7:0] ext_written = wr_ext ? (reg_wdata & EXT_LINE_MASK) : ext_line_ff; // [R18]
    wire [7:0] nxt_ext_line = ext_written | ext_set; // [R17]
    wire [7:0] periph_written = wr_periph ? (reg_wdata & PERIPH_SW_MASK) : periph_flags_ff;
    wire [7:0] nxt_periph_flags = (periph_written | periph_set) & PERIPH_SW_MASK; // [R20]
    wire nxt_prio_mode = wr_rst ? reg_wdata[PRIO_MODE_BIT] : prio_mode_ff; // [R23]

    // Receive and transmit flags are live copies of the buffer state
    wire [7:0] periph_view = periph_flags_ff |
                             {2'h0, serial_receive_full, serial_transmit_empty, 4'h0}; // [R21] [R22]

    // Read multiplexer; unmapped indices answer zero
    wire [7:0] rd_mux = sel_core ? core_ctl_ff :
                        sel_edge ? edge_prio_ff :
                        sel_ext ? ext_line_ff :
                        sel_periph ? periph_view :
                        sel_rst ? {prio_mode_ff, 7'h00} : 8'h00;
    wire [7:0] nxt_reg_rdata = reg_rd ? rd_mux : 8'h00;

    // Per-source active terms: flag and individual enable
    wire tmr0_act = core_ctl_ff[TMR0_FLAG_BIT] && core_ctl_ff[TMR0_EN_BIT]; // [R7]
    wire ext0_act = core_ctl_ff[EXT0_FLAG_BIT] && core_ctl_ff[EXT0_EN_BIT]; // [R7]
    wire port_act = core_ctl_ff[PORTCHG_FLAG_BIT] && core_ctl_ff[PORTCHG_EN_BIT]; // [R7]
    wire ext1_act = ext_line_ff[EXT1_FLAG_BIT] && ext_line_ff[EXT1_EN_BIT]; // [R16]
    wire ext2_act = ext_line_ff[EXT2_FLAG_BIT] && ext_line_ff[EXT2_EN_BIT]; // [R16]
    wire [4:0] core_act = {ext2_act, ext1_act, port_act, ext0_act, tmr0_act};
    wire [7:0] periph_act = periph_view & periph_enable;

    // Priority of each core source; line zero is always high priority
    wire [4:0] core_prio = {ext_line_ff[EXT2_PRIO_BIT], ext_line_ff[EXT1_PRIO_BIT],
                            edge_prio_ff[PORTCHG_PRIO_BIT], 1'b1,
                            edge_prio_ff[TMR0_PRIO_BIT]}; // [R14] [R15]

    wire [12:0] all_act = {periph_act, core_act};
    wire [12:0] all_prio = {periph_priority, core_prio};
    wire any_high_src = |(all_act & all_prio);
    wire any_low_src = |(all_act & ~all_prio);

    // Compatible mode: bit 7 gates all, bit 6 additionally gates peripherals
    wire compat_req = core_ctl_ff[GLOBAL_EN_BIT] &&
                      ((|core_act) || (core_ctl_ff[PERIPH_EN_BIT] && (|periph_act))); // [R3] [R5] [R26]

    // Priority mode: a low request also needs the high gate, so a running
    // high priority handler is never interrupted by a low source
    wire prio_high_req = core_ctl_ff[GLOBAL_EN_BIT] && any_high_src; // [R4] [R26]
    wire prio_low_req = core_ctl_ff[GLOBAL_EN_BIT] && core_ctl_ff[PERIPH_EN_BIT] && any_low_src; // [R6]

    wire nxt_high_irq_req = prio_mode_ff ? prio_high_req : compat_req; // [R23]
    wire nxt_low_irq_req = prio_mode_ff && prio_low_req && !prio_high_req;
    wire [23:0] nxt_irq_vector = nxt_low_irq_req ? VEC_LOW : VEC_HIGH; // [R24]

    // Pull-ups follow the port latch unless globally disabled
    wire [7:0] nxt_pullup_en = edge_prio_ff[PULLUP_DIS_BIT] ? 8'h00 : port_latch; // [R12]

    // Control and flag registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            core_ctl_ff <= CORE_CTL_RST;
            edge_prio_ff <= EDGE_PRIO_RST;
            ext_line_ff <= EXT_LINE_RST;
            periph_flags_ff <= PERIPH_FLAGS_RST;
            prio_mode_ff <= PRIO_MODE_RST;
        end else begin
            core_ctl_ff <= nxt_core_ctl;
            edge_prio_ff <= nxt_edge_prio;
            ext_line_ff <= nxt_ext_line;
            periph_flags_ff <= nxt_periph_flags;
            prio_mode_ff <= nxt_prio_mode;
        end
    end

    // Port snapshot: a port read ends the mismatch so the flag can be cleared
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            port_seen_ff <= 4'h0;
        end else if (port_b_read) begin
            port_seen_ff <= upper_port_nibble; // [R11]
        end
    end

    // Registered outputs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= 8'h00;
            high_irq_req_ff <= 1'b0;
            low_irq_req_ff <= 1'b0;
            irq_vector_ff <= VEC_HIGH;
            pullup_en_ff <= 8'h00;
        end else begin
            reg_rdata_ff <= nxt_reg_rdata;
            high_irq_req_ff <= nxt_high_irq_req;
            low_irq_req_ff <= nxt_low_irq_req;
            irq_vector_ff <= nxt_irq_vector;
            pullup_en_ff <= nxt_pullup_en;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign high_irq_req = high_irq_req_ff;
    assign low_irq_req = low_irq_req_ff;
    assign irq_vector = irq_vector_ff;
    assign pullup_en = pullup_en_ff;

    // Checks on flag setting, gating, response and register view
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    chk_timer_flag_set: assert property ( // [R1] [R8]
        timer_zero_overflow |=> core_ctl_ff[TMR0_FLAG_BIT] [*2] or
        (core_ctl_ff[TMR0_FLAG_BIT] && wr_core)
    ) else $error("timer overflow flag not set");

    chk_line_zero_flag: assert property ( // [R9]
        ext_lines.edge_hit[0] |=> core_ctl_ff[EXT0_FLAG_BIT]
    ) else $error("line zero flag not set on edge");

    chk_port_mismatch_sets: assert property ( // [R10] [R11]
        port_mismatch |=> core_ctl_ff[PORTCHG_FLAG_BIT]
    ) else $error("port change flag missed a mismatch");

    chk_port_read_ends: assert property ( // [R11]
        port_b_read |=> !port_mismatch || $changed(upper_port_nibble)
    ) else $error("port read did not end the mismatch");

    chk_compat_gate_all: assert property ( // [R3]
        (!prio_mode_ff && !core_ctl_ff[GLOBAL_EN_BIT]) |=> !high_irq_req_ff && !low_irq_req_ff
    ) else $error("request while global enable clear");

    chk_prio_high_gate: assert property ( // [R4]
        (prio_mode_ff && !core_ctl_ff[GLOBAL_EN_BIT]) |=> !high_irq_req_ff
    ) else $error("high request while high gate clear");

    chk_periph_gate: assert property ( // [R5]
        (!prio_mode_ff && !core_ctl_ff[PERIPH_EN_BIT] && core_act == 5'h00) |=> !high_irq_req_ff
    ) else $error("peripheral request while peripheral gate clear");

    chk_prio_low_gate: assert property ( // [R6]
        (prio_mode_ff && !core_ctl_ff[PERIPH_EN_BIT]) |=> !low_irq_req_ff
    ) else $error("low request while low gate clear");

    chk_ack_clears_gate: assert property ( // [R25]
        (irq_ack && !prio_mode_ff) |=> !core_ctl_ff[GLOBAL_EN_BIT]
    ) else $error("response did not clear the global enable");

    chk_low_vector: assert property ( // [R24]
        (low_irq_req_ff |-> irq_vector_ff == VEC_LOW) and
        (high_irq_req_ff |-> irq_vector_ff == VEC_HIGH)
    ) else $error("vector does not match request level");

    chk_reserved_zero: assert property ( // [R18]
        (reg_rd && sel_edge) |=> reg_rdata_ff[3] == 1'b0 && reg_rdata_ff[1] == 1'b0
    ) else $error("unimplemented bit read as one");

    chk_rx_follows: assert property ( // [R21]
        (reg_rd && sel_periph) |=> reg_rdata_ff[RX_FULL_BIT] == $past(serial_receive_full)
    ) else $error("receive flag does not follow buffer state");

    chk_pullup_off: assert property ( // [R12]
        edge_prio_ff[PULLUP_DIS_BIT] |=> pullup_en_ff == 8'h00
    ) else $error("pull-ups active while disabled");

    cov_high_request: cover property (high_irq_req_ff ##1 irq_ack);
    cov_low_request: cover property (low_irq_req_ff && prio_mode_ff);
    cov_port_change: cover property (port_mismatch ##[1:20] port_b_read);
    cov_line_two_edge: cover property (ext_lines.edge_hit[2]);

endmodule

// ===== verilog/irq_ctl_pkg.sv
// Constants shared by the interrupt control flag block and its edge detector.
// Assumes an 8-bit register port with word indices in the low address bits.
package irq_ctl_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] CORE_CTL_IDX = 3'h0;
    localparam logic [2:0] EDGE_PRIO_IDX = 3'h1;
    localparam logic [2:0] EXT_LINE_IDX = 3'h2;
    localparam logic [2:0] PERIPH_FLAGS_IDX = 3'h3;
    localparam logic [2:0] RESET_CTL_IDX = 3'h4;

    // Values after power-on reset
    localparam logic [7:0] CORE_CTL_RST = 8'h00;
    localparam logic [7:0] EDGE_PRIO_RST = 8'hF5;
    localparam logic [7:0] EXT_LINE_RST = 8'hC0;
    localparam logic [7:0] PERIPH_FLAGS_RST = 8'h00;
    localparam logic PRIO_MODE_RST = 1'b0;

    // Implemented bits of the partly populated registers, and the stored peripheral flag bits
    localparam logic [7:0] EDGE_PRIO_MASK = 8'hF5;
    localparam logic [7:0] EXT_LINE_MASK = 8'hDB;
    localparam logic [7:0] PERIPH_SW_MASK = 8'hCF;

    // Core control register fields
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_EN_BIT = 6;
    localparam int TMR0_EN_BIT = 5;
    localparam int EXT0_EN_BIT = 4;
    localparam int PORTCHG_EN_BIT = 3;
    localparam int TMR0_FLAG_BIT = 2;
    localparam int EXT0_FLAG_BIT = 1;
    localparam int PORTCHG_FLAG_BIT = 0;

    // Edge and priority control fields
    localparam int PULLUP_DIS_BIT = 7;
    localparam int EDGE0_BIT = 6;
    localparam int EDGE1_BIT = 5;
    localparam int EDGE2_BIT = 4;
    localparam int TMR0_PRIO_BIT = 2;
    localparam int PORTCHG_PRIO_BIT = 0;

    // External line control fields
    localparam int EXT2_PRIO_BIT = 7;
    localparam int EXT1_PRIO_BIT = 6;
    localparam int EXT2_EN_BIT = 4;
    localparam int EXT1_EN_BIT = 3;
    localparam int EXT2_FLAG_BIT = 1;
    localparam int EXT1_FLAG_BIT = 0;

    // Peripheral flag fields and the priority mode bit
    localparam int RX_FULL_BIT = 5;
    localparam int TX_EMPTY_BIT = 4;
    localparam int PRIO_MODE_BIT = 7;

    // Vector addresses presented to the core
    localparam logic [23:0] VEC_HIGH = 24'h00_0008;
    localparam logic [23:0] VEC_LOW = 24'h00_0018;

endpackage
